// ===== src/ssap_port.sv
// What this block does
// [R1] master drives bit clock and word select; slave takes them; data always out
// [R2] channel words are 16 bits, sent most significant bit first
// [R3] word MSB leaves one bit clock after word-select changes, on a falling edge
// [R4] left word while word select is low, right word while it is high
// [R5] output bits change on falling edges; receiver samples on rising edges
// [R6] master frame is 48 kHz with 32 or 50 bit clocks per frame
// [R7] master bit clock comes from reference clock via an N/M fractional divider
// [R8] slave works with any external bit clock up to 3.072 MHz
// [R9] generated bit clock phases differ by one reference cycle at most, each phase at least 0.35 period
// [R10] external slave clock keeps each phase at least 0.35 of its period
// [R11] slots beyond the 16 data bits send zeros and received extras are dropped
`timescale 1ns/100ps
module ssap_port #(
  parameter logic [ssap_pkg::ACC_W-1:0] DIV_M = ssap_pkg::DIV_M_DEF,
  parameter logic [ssap_pkg::ACC_W-1:0] DIV_N_SHORT =
    ssap_pkg::DIV_N_SHORT_DEF,
  parameter logic [ssap_pkg::ACC_W-1:0] DIV_N_LONG = ssap_pkg::DIV_N_LONG_DEF
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic master_mode,
  input wire logic frame_long,
  input wire logic bclk_sense,
  output logic bclk_drive,
  output logic bclk_oe,
  input wire logic ws_sense,
  output logic ws_drive,
  output logic ws_oe,
  input wire logic sd_in,
  output logic sd_out,
  input wire logic tx_valid,
  input wire ssap_pkg::ssap_pair_t tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output ssap_pkg::ssap_pair_t rx_data
);
  localparam int W = ssap_pkg::WORD_BITS;
  localparam int AW = ssap_pkg::ACC_W;

  logic mode_q;
  logic long_q;
  logic [AW-1:0] acc_q;
  logic [AW-1:0] step;
  logic [AW:0] acc_sum;
  logic tick;
  logic bclk_q;
  logic sck_prev_q;
  logic fall_en;
  logic rise_en;
  logic [5:0] slot_q;
  logic [5:0] slot_d;
  logic [5:0] frame_last;
  logic [5:0] half;
  logic ws_q;
  logic ws_now;
  logic ws_seen_q;
  logic chg;
  logic ld_q;
  logic ld_ch_q;
  ssap_pkg::ssap_pair_t cur_q;
  logic [W-1:0] load_word;
  logic load_msb;
  logic [W-1:0] sh_q;
  logic [4:0] rem_q;
  logic sdo_q;
  logic [4:0] rcnt_q;
  logic [W-1:0] rsh_q;
  logic [W-1:0] rx_next;
  logic [W-1:0] rleft_q;
  logic buf_valid;
  logic buf_pop;
  ssap_pkg::ssap_pair_t buf_data;

  // mode pins are registered; pin direction follows the registered mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= ssap_pkg::RST_MASTER;
      long_q <= 1'b0;
      bclk_oe <= ssap_pkg::RST_MASTER;
      ws_oe <= ssap_pkg::RST_MASTER;
    end else begin
      mode_q <= master_mode;
      long_q <= frame_long;
      bclk_oe <= master_mode; // [R1]
      ws_oe <= master_mode; // [R1]
    end
  end

  // fractional divider: one tick per half bit period, so the two phases
  // differ by one reference cycle at most, far above the 0.35 floor
  assign step = long_q ? DIV_N_LONG : DIV_N_SHORT; // [R6]
  assign acc_sum = {1'b0, acc_q} + {1'b0, step};
  assign tick = mode_q && (acc_sum >= {1'b0, DIV_M});

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
      bclk_q <= ssap_pkg::RST_BCLK;
    end else if (!mode_q) begin
      acc_q <= '0;
      bclk_q <= ssap_pkg::RST_BCLK;
    end else if (tick) begin
      acc_q <= AW'(acc_sum - {1'b0, DIV_M}); // [R7]
      bclk_q <= ~bclk_q; // [R9]
    end else begin
      acc_q <= acc_sum[AW-1:0]; // [R7]
    end
  end

  assign bclk_drive = bclk_q;

  // slave edges come from the sampled pin; the clock must hold each phase
  // for at least one reference cycle or an edge is missed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= bclk_sense; // [R8]
    end
  end

  assign fall_en = mode_q ? (tick && bclk_q) : (sck_prev_q && !bclk_sense);
  assign rise_en = mode_q ? (tick && !bclk_q) : (!sck_prev_q && bclk_sense);

  // master frame counter and word select, both moved on falling edges
  assign frame_last = long_q ? 6'(ssap_pkg::FRAME_BITS_LONG - 1)
                             : 6'(ssap_pkg::FRAME_BITS_SHORT - 1);
  assign half = long_q ? 6'(ssap_pkg::FRAME_BITS_LONG / 2)
                       : 6'(ssap_pkg::FRAME_BITS_SHORT / 2);
  assign slot_d = (slot_q >= frame_last) ? '0 : slot_q + 1'b1;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      slot_q <= '0;
      ws_q <= ssap_pkg::RST_WS;
    end else if (!mode_q) begin
      slot_q <= '0;
      ws_q <= ssap_pkg::RST_WS;
    end else if (fall_en) begin
      slot_q <= slot_d; // [R6]
      ws_q <= (slot_d >= half); // [R4]
    end
  end

  assign ws_drive = ws_q;

  // word select is judged at rising edges in both modes
  assign ws_now = mode_q ? ws_q : ws_sense;
  assign chg = (ws_now != ws_seen_q);
  assign buf_pop = rise_en && chg && !ws_now;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ws_seen_q <= ssap_pkg::RST_WS;
      ld_q <= 1'b0;
      ld_ch_q <= 1'b0;
    end else if (rise_en) begin
      ws_seen_q <= ws_now;
      ld_q <= chg; // [R3]
      ld_ch_q <= ws_now;
    end else if (fall_en) begin
      ld_q <= 1'b0;
    end
  end

  // a whole stereo pair is taken at each left-channel start; an empty
  // buffer sends silence rather than repeating the previous pair
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= '0;
    end else if (buf_pop) begin
      cur_q <= buf_valid ? buf_data : '0;
    end
  end

  assign load_word = ld_ch_q ? cur_q.right : cur_q.left; // [R4]
  assign load_msb = load_word[W-1];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= ssap_pkg::RST_SDO;
      sh_q <= '0;
      rem_q <= '0;
    end else if (fall_en) begin // [R5]
      if (ld_q) begin
        sdo_q <= load_msb; // [R2] [R3]
        sh_q <= {load_word[W-2:0], 1'b0};
        rem_q <= 5'(W - 1);
      end else begin
        sdo_q <= (rem_q != '0) && sh_q[W-1]; // [R11]
        sh_q <= {sh_q[W-2:0], 1'b0};
        if (rem_q != '0) begin
          rem_q <= rem_q - 1'b1;
        end
      end
    end
  end

  assign sd_out = sdo_q;

  // receive: the bit at the word-select change still belongs to the old word
  assign rx_next = (rcnt_q < 5'(W)) ? {rsh_q[W-2:0], sd_in} : rsh_q; // [R11]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsh_q <= '0;
      rcnt_q <= '0;
      rleft_q <= '0;
    end else if (rise_en) begin // [R5]
      if (chg) begin
        if (!ws_seen_q) begin
          rleft_q <= rx_next; // [R4]
        end
        rsh_q <= '0;
        rcnt_q <= '0;
      end else begin
        rsh_q <= rx_next; // [R2]
        if (rcnt_q < 5'(W)) begin
          rcnt_q <= rcnt_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_valid <= rise_en && chg && ws_seen_q;
      if (rise_en && chg && ws_seen_q) begin
        rx_data <= '{left: rleft_q, right: rx_next};
      end
    end
  end

  ssap_buf #(
    .WIDTH($bits(ssap_pkg::ssap_pair_t)),
    .DEPTH(2)
  ) u_txbuf (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  // checking helpers
  logic ws_h_q;
  logic [5:0] fcnt_q;
  logic [7:0] hlen_q;
  logic [7:0] plen_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ws_h_q <= 1'b0;
      fcnt_q <= '0;
    end else begin
      ws_h_q <= ws_q;
      if (ws_q != ws_h_q) begin
        fcnt_q <= '0;
      end else if (fall_en) begin
        fcnt_q <= fcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hlen_q <= 8'h01;
      plen_q <= 8'h00;
    end else if (!mode_q) begin
      hlen_q <= 8'h01;
      plen_q <= 8'h00;
    end else if (tick) begin
      hlen_q <= 8'h01;
      plen_q <= hlen_q;
    end else if (hlen_q != 8'hff) begin
      hlen_q <= hlen_q + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence load_fall_s;
    fall_en && ld_q;
  endsequence

  sequence master_steady_s;
    mode_q && $stable(long_q);
  endsequence

  pin_dir_a: assert property (master_mode |=> bclk_oe && ws_oe) // [R1]
    else $error("pin enables do not follow master mode");
  msb_first_a: assert property ( // [R3]
    load_fall_s |=> sd_out == $past(load_msb) && rem_q == 5'(W - 1))
    else $error("word msb not sent after word select change");
  pad_zero_a: assert property ( // [R11]
    fall_en && !ld_q && rem_q == '0 |=> !sd_out)
    else $error("spare slot not zero");
  out_on_fall_a: assert property (!$stable(sd_out) |-> $past(fall_en)) // [R5]
    else $error("data out changed off a falling edge");
  left_low_a: assert property ( // [R4]
    master_steady_s and (fall_en && slot_d == '0) |=> !ws_drive)
    else $error("word select not low at left start");
  right_high_a: assert property ( // [R4]
    master_steady_s and (fall_en && slot_d == half) |=> ws_drive)
    else $error("word select not high at right start");
  frame_len_a: assert property ( // [R6]
    master_steady_s and (ws_q != ws_h_q) |-> fcnt_q == half)
    else $error("wrong bit clocks per half frame");
  duty_a: assert property ( // [R9]
    master_steady_s and tick and (plen_q != 8'h00)
      |-> hlen_q <= plen_q + 8'h01 && plen_q <= hlen_q + 8'h01)
    else $error("bit clock phases uneven");
  acc_range_a: assert property (acc_q < DIV_M) // [R7]
    else $error("divider accumulator out of range");
  rx_pair_a: assert property ( // [R4]
    rx_valid |-> $past(rise_en) && $past(ws_seen_q) && !$past(ws_now))
    else $error("received pair not closed at left start");

endmodule : ssap_port

// ===== src/ssap_pkg.sv
package ssap_pkg;

  // serial word and frame geometry
  localparam int WORD_BITS = 16;
  localparam int FRAME_BITS_SHORT = 32;
  localparam int FRAME_BITS_LONG = 50;

  // rates in hertz
  localparam int CLK_HZ = 250_000_000;
  localparam int FRAME_HZ = 48_000;
  localparam int SLAVE_MAX_BCLK_HZ = 3_072_000;

  // fractional divider: the accumulator adds N each cycle and wraps at M,
  // one wrap per half bit-clock period
  localparam int ACC_W = 28;
  localparam logic [ACC_W-1:0] DIV_M_DEF = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] DIV_N_SHORT_DEF =
    ACC_W'(2 * FRAME_HZ * FRAME_BITS_SHORT);
  localparam logic [ACC_W-1:0] DIV_N_LONG_DEF =
    ACC_W'(2 * FRAME_HZ * FRAME_BITS_LONG);

  // slave edges: least clock cycles in one bit-clock phase at full rate
  // scaled down first so the product stays inside a 32-bit int
  localparam int SLAVE_MIN_PHASE_CYC =
    (CLK_HZ / 100 * 35) / SLAVE_MAX_BCLK_HZ;

  // values after reset
  localparam logic RST_MASTER = 1'b0;
  localparam logic RST_BCLK = 1'b0;
  localparam logic RST_WS = 1'b0;
  localparam logic RST_SDO = 1'b0;

  typedef struct packed {
    logic [WORD_BITS-1:0] left;
    logic [WORD_BITS-1:0] right;
  } ssap_pair_t;

endpackage : ssap_pkg

// ===== src/ssap_buf.sv
`timescale 1ns/100ps
module ssap_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

  // flags kept as flops so both handshake outputs leave from a register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != (AW + 1)'(DEPTH));
      out_valid <= (cnt_d != '0);
    end
  end

endmodule : ssap_buf

// ===== testbench/ssap_codec.sv
`timescale 1ns/100ps
module ssap_codec #(
  parameter int SLV_PH = 41
) (
  input wire logic clock,
  input wire logic clr,
  input wire logic bclk_drive,
  input wire logic bclk_oe,
  input wire logic ws_drive,
  input wire logic ws_oe,
  input wire logic sd_out,
  input wire ssap_pkg::ssap_pair_t send,
  output logic bclk,
  output logic ws,
  output logic sd_in,
  output logic got_valid,
  output ssap_pkg::ssap_pair_t got,
  output int pad_bad,
  output int frame_cyc,
  output int ph_min,
  output int ph_max
);
  logic sclk = 1'b0;
  logic sws = 1'b0;
  logic ws_l = 1'b0;
  logic b_l = 1'b0;
  logic [15:0] w = '0;
  logic [15:0] gl = '0;
  int n = 16;
  int sl = 0;
  int sc = 0;
  int hc = 0;
  longint t_l = 0;
  assign bclk = bclk_oe ? bclk_drive : sclk;
  assign ws = ws_oe ? ws_drive : sws;
  initial begin
    {sd_in, got_valid, got, pad_bad, frame_cyc, ph_max} = '0;
    ph_min = 9999;
  end
  always @(posedge clock) begin
    // own clock only while the device listens, phases 41 cycles each
    sc <= bclk_oe ? 0 : sc + 1;
    if (!bclk_oe && sc >= SLV_PH - 1) begin
      sclk <= ~sclk;
      sc <= 0;
    end
    b_l <= bclk;
    hc <= (bclk != b_l) ? 1 : hc + 1;
    if (clr) begin
      ph_min <= 9999;
      ph_max <= 0;
    end else if (bclk != b_l && bclk_oe) begin
      if (hc < ph_min) ph_min <= hc;
      if (hc > ph_max) ph_max <= hc;
    end
  end
  always @(posedge bclk) begin
    if (n < 16) w[15-n] = sd_out;
    else if (sd_out !== 1'b0) pad_bad++;
    n++;
    // the bit seen with the new word select still closes the old word
    got_valid <= (ws !== ws_l) && ws_l;
    if (ws !== ws_l) begin
      if (ws_l) got <= {gl, w};
      else gl = w;
      if (!ws) frame_cyc <= int'(($time - t_l) / 4);
      if (!ws) t_l = $time;
      ws_l = ws;
      n = 0;
    end
  end
  always @(negedge bclk) begin
    // spare slots carry ones that the device has to drop; the channel
    // follows the last rising edge, as the pin moves with this very edge
    sd_in <= n > 15 ? 1'b1 : ws_l ? send.right[15-n] : send.left[15-n];
  end
  always @(negedge sclk) begin
    sl <= (sl + 1) % 32;
    if (sl % 16 == 15) sws <= ~sws;
  end
endmodule : ssap_codec

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam logic [27:0] M = 28'h140;
  localparam logic [27:0] NS = 28'h10;
  localparam logic [27:0] NL = 28'h19;
  localparam int FR = 64 * M / NS;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic master_mode = 1'b1;
  logic frame_long = 1'b0;
  logic tx_valid = 1'b0;
  logic clr = 1'b1;
  ssap_pkg::ssap_pair_t tx_data = '0;
  ssap_pkg::ssap_pair_t send = '0;
  ssap_pkg::ssap_pair_t got;
  ssap_pkg::ssap_pair_t rx_data;
  ssap_pkg::ssap_pair_t q[$];
  logic bclk, ws, sd_in, sd_out, got_valid, rx_valid, tx_ready;
  logic bclk_drive, bclk_oe, ws_drive, ws_oe;
  int pad_bad, frame_cyc, ph_min, ph_max;
  int fails = 0;
  int num_checks = 0;
  int rx_skip = 0;
  int k;
  logic [31:0] seed = 32'h69f44adf;
  always #2 clock = ~clock;
  ssap_port #(.DIV_M(M), .DIV_N_SHORT(NS), .DIV_N_LONG(NL)) u_dut (
    .clock(clock), .arst_n(arst_n), .master_mode(master_mode),
    .frame_long(frame_long), .bclk_sense(bclk), .bclk_drive(bclk_drive),
    .bclk_oe(bclk_oe), .ws_sense(ws), .ws_drive(ws_drive), .ws_oe(ws_oe),
    .sd_in(sd_in), .sd_out(sd_out), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data)
  );
  ssap_codec u_codec (
    .clock(clock), .clr(clr), .bclk_drive(bclk_drive), .bclk_oe(bclk_oe),
    .ws_drive(ws_drive), .ws_oe(ws_oe), .sd_out(sd_out), .send(send),
    .bclk(bclk), .ws(ws), .sd_in(sd_in), .got_valid(got_valid),
    .got(got), .pad_bad(pad_bad), .frame_cyc(frame_cyc),
    .ph_min(ph_min), .ph_max(ph_max)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask : chk
  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // each channel keeps a set bit so that underrun frames are told apart
  task automatic put;
    seed = xs(seed);
    tx_data = seed | 32'h00010001;
    tx_valid = 1'b1;
    for (k = 0; k < 9000 && tx_ready !== 1'b1; k++) @(posedge clock) #1;
    @(posedge clock) #1;
    q.push_back(tx_data);
  endtask : put
  always @(posedge got_valid) begin
    #1;
    if (got !== '0) begin
      chk("tx queue", 32'h1, q.size() > 0);
      if (q.size() > 0) chk("tx pair", q.pop_front(), got);
    end
  end
  always @(posedge clock) if (rx_valid === 1'b1) begin
    if (rx_skip > 0) rx_skip--;
    else chk("rx pair", send, rx_data);
  end
  initial begin
    for (int ph = 0; ph < 3; ph++) begin
      arst_n = 1'b0;
      master_mode = ph < 2;
      frame_long = ph == 1;
      seed = xs(seed);
      send = seed;
      rx_skip = 2;
      clr = 1'b1;
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      put();
      put();
      tx_valid = 1'b0;
      @(posedge clock) #1;
      chk("ready when full", 32'h0, tx_ready);
      put();
      put();
      tx_valid = 1'b0;
      clr = 1'b0;
      for (k = 0; k < 30000 && q.size() != 0; k++) @(posedge clock);
      repeat (8000) @(posedge clock);
      #1;
      chk("pairs left", 32'h0, q.size());
      chk("bclk driven", master_mode, bclk_oe);
      chk("ws driven", master_mode, ws_oe);
      chk("frame", ph < 2 ? FR : 64 * 41, frame_cyc);
      if (ph < 2) chk("low phase", frame_long ? M / NL : M / NS, ph_min);
      if (ph < 2) chk("hi phase", M / (frame_long ? NL : NS) + frame_long, ph_max);
    end
    chk("pad bits", 32'h0, pad_bad);
    give_verdict();
  end
  initial begin
    #360000;
    fails++;
    give_verdict();
  end
endmodule : testbench
